// file: verilog/boot_link.sv
/*
  Boot-time link setup: bring-up, choice of serial, USB or mailbox link,
  ack and code exchange, then hand-over to the command phase.
  Assumes pipes and register port on i_clk; pins and mode value are not.
*/
// Contract
// (RULE_01) Bring-up, then link setting; order fixed.
// (RULE_02) Three serial 00h in a row pick serial.
// (RULE_03) Three USB 00h in a row pick USB.
// (RULE_04) Other value or other-link byte clears zero count.
// (RULE_05) Pin high, no magic, user area used: soft reset.
// (RULE_06) Pin high and magic A5h: mailbox, no zero hunt.
// (RULE_07) No mailbox: hear both links, ack 00h on winner.
// (RULE_08) Answer generic 55h with boot code C6h.
// (RULE_09) Awaiting generic: drop other bytes, send nothing.
// (RULE_10) Command phase once boot code sent.
// (RULE_11) Host sends 00h at 9600 bps until ack.
// (RULE_12) Host repeats 00h until ack, serial and USB.
// (RULE_13) No ack: host restarts from reset.
// (RULE_14) New firmware: pull-up after init, drive after three zeros.
// (RULE_15) USB enumerable; bytes count once configured.
// (RULE_16) Host opens mailbox: reset, enable, power up, A5h, release.
// (RULE_17) Host closes mailbox: reset, 00h, power down, disable.
// (RULE_18) Host checks mailbox flags before each word access.
// (RULE_19) Serial 9600 bps until changed, 8N1, LSB first.
// (RULE_20) Capture pin and magic once after reset.
`default_nettype none

module boot_link #(
  parameter logic [15:0] BIT_CYCLES = 16'(boot_link_pkg::BIT_CYCLES_INIT)
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_boot_mode_pin,
  input wire logic [7:0] i_debug_boot_mode,
  input wire logic i_user_area_blank,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_txd_pullup_en,
  output logic o_usb_enumerable,
  input wire logic i_usb_configured,
  input wire logic i_usb_rx_valid,
  input wire logic [7:0] i_usb_rx_data,
  output logic o_usb_tx_valid,
  output logic [7:0] o_usb_tx_data,
  input wire logic i_usb_tx_ready,
  input wire logic i_mbox_rx_valid,
  input wire logic [7:0] i_mbox_rx_data,
  output logic o_mbox_tx_valid,
  output logic [7:0] o_mbox_tx_data,
  input wire logic i_mbox_tx_ready,
  output logic o_soft_reset,
  output logic o_cmd_phase,
  output logic [1:0] o_link,
  output logic o_cmd_rx_valid,
  output logic [7:0] o_cmd_rx_data,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  boot_link_pkg::boot_state_e state_reg, state_next;
  boot_link_pkg::link_e link_reg, zero_src_reg;
  logic [3:0] init_cnt_reg;
  logic [1:0] zero_cnt_reg;
  logic mode_meta_reg, mode_sync_reg, mode_latched_reg, fw_ge3_reg, tx_issued_reg;
  logic [7:0] dbm_meta_reg, dbm_sync_reg, dbm_latched_reg, uart_rx_data, sel_rx_data, tx_byte;
  logic [15:0] bit_cycles_reg;
  logic uart_rx_valid, uart_tx_start, uart_tx_busy, uart_txd, usb_rx, both_rx;
  logic uart_zero, usb_zero, hit_uart, hit_usb, sel_rx_valid, sending, send_done;

  // ----------------------------------------------------------------
  // Input synchronisers and serial transceiver
  // ----------------------------------------------------------------
  // The debug mode value is static across reset release, so a
  // per-bit two-stage capture is enough; it is only used once.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
      dbm_meta_reg <= 8'h00;
      dbm_sync_reg <= 8'h00;
    end else begin
      mode_meta_reg <= i_boot_mode_pin;
      mode_sync_reg <= mode_meta_reg;
      dbm_meta_reg <= i_debug_boot_mode;
      dbm_sync_reg <= dbm_meta_reg;
    end
  end

  // (RULE_19) Serial frame engine
  uart_link u_uart (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_bit_cycles(bit_cycles_reg),
    .i_rxd(i_rxd),
    .o_rx_valid(uart_rx_valid),
    .o_rx_data(uart_rx_data),
    .i_tx_start(uart_tx_start),
    .i_tx_data(tx_byte),
    .o_tx_busy(uart_tx_busy),
    .o_txd(uart_txd)
  );

  // ----------------------------------------------------------------
  // Byte events and transmit path
  // ----------------------------------------------------------------
  // (RULE_15) USB bytes count only when configured
  assign usb_rx = i_usb_rx_valid && i_usb_configured;
  assign both_rx = uart_rx_valid && usb_rx;
  assign uart_zero = uart_rx_valid && !usb_rx && (uart_rx_data == boot_link_pkg::SYNC_BYTE);
  assign usb_zero = usb_rx && !uart_rx_valid && (i_usb_rx_data == boot_link_pkg::SYNC_BYTE);

  // (RULE_02) Third serial zero in a row
  assign hit_uart = (state_reg == boot_link_pkg::ST_WAIT_ZERO) && uart_zero &&
                    (zero_src_reg == boot_link_pkg::LINK_UART) &&
                    ((zero_cnt_reg + 2'h1) == boot_link_pkg::ZERO_RUN);
  // (RULE_03) Third USB zero in a row
  assign hit_usb = (state_reg == boot_link_pkg::ST_WAIT_ZERO) && usb_zero &&
                   (zero_src_reg == boot_link_pkg::LINK_USB) &&
                   ((zero_cnt_reg + 2'h1) == boot_link_pkg::ZERO_RUN);
  // Received byte on the established link only
  always_comb begin
    sel_rx_valid = 1'b0;
    sel_rx_data = 8'h00;
    case (link_reg)
      boot_link_pkg::LINK_UART: begin
        sel_rx_valid = uart_rx_valid;
        sel_rx_data = uart_rx_data;
      end
      boot_link_pkg::LINK_USB: begin
        sel_rx_valid = usb_rx;
        sel_rx_data = i_usb_rx_data;
      end
      boot_link_pkg::LINK_MBOX: begin
        sel_rx_valid = i_mbox_rx_valid;
        sel_rx_data = i_mbox_rx_data;
      end
      default: sel_rx_valid = 1'b0;
    endcase
  end

  // (RULE_08) Boot code answers the generic code
  assign sending = (state_reg == boot_link_pkg::ST_SEND_ACK) ||
                   (state_reg == boot_link_pkg::ST_SEND_BOOT);
  assign tx_byte = (state_reg == boot_link_pkg::ST_SEND_BOOT) ?
                   boot_link_pkg::BOOT_CODE : boot_link_pkg::ACK_BYTE;
  assign uart_tx_start = sending && (link_reg == boot_link_pkg::LINK_UART) && !tx_issued_reg;
  assign o_usb_tx_valid = sending && (link_reg == boot_link_pkg::LINK_USB);
  assign o_mbox_tx_valid = sending && (link_reg == boot_link_pkg::LINK_MBOX);
  assign o_usb_tx_data = o_usb_tx_valid ? tx_byte : 8'h00;
  assign o_mbox_tx_data = o_mbox_tx_valid ? tx_byte : 8'h00;
  // Serial byte counts as sent once the stop bit has left the line
  assign send_done = (link_reg == boot_link_pkg::LINK_UART) ? tx_issued_reg && !uart_tx_busy :
                     (link_reg == boot_link_pkg::LINK_USB) ? i_usb_tx_ready :
                     (link_reg == boot_link_pkg::LINK_MBOX) && i_mbox_tx_ready;
  // Remembers that the serial byte was launched in this send phase
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_issued_reg <= 1'b0;
    end else if (!sending || send_done) begin
      tx_issued_reg <= 1'b0;
    end else if (uart_tx_start) begin
      tx_issued_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // (RULE_01) Bring-up before link setting
      boot_link_pkg::ST_INIT: begin
        if (init_cnt_reg == boot_link_pkg::INIT_CYCLES) begin
          state_next = boot_link_pkg::ST_SAMPLE;
        end
      end
      boot_link_pkg::ST_SAMPLE: begin
        // (RULE_06) Magic selects mailbox
        if (mode_sync_reg && (dbm_sync_reg == boot_link_pkg::MAGIC_CODE)) begin
          state_next = boot_link_pkg::ST_WAIT_GENERIC;
        // (RULE_05) Software reset condition
        end else if (mode_sync_reg && !i_user_area_blank) begin
          state_next = boot_link_pkg::ST_SW_RESET;
        end else begin
          state_next = boot_link_pkg::ST_WAIT_ZERO;
        end
      end
      // (RULE_07) Listen on both links
      boot_link_pkg::ST_WAIT_ZERO: begin
        if (hit_uart || hit_usb) begin
          state_next = boot_link_pkg::ST_SEND_ACK;
        end
      end
      boot_link_pkg::ST_SEND_ACK: begin
        if (send_done) begin
          state_next = boot_link_pkg::ST_WAIT_GENERIC;
        end
      end
      // (RULE_09) Other values are dropped
      boot_link_pkg::ST_WAIT_GENERIC: begin
        if (sel_rx_valid && (sel_rx_data == boot_link_pkg::GENERIC_CODE)) begin
          state_next = boot_link_pkg::ST_SEND_BOOT;
        end
      end
      // (RULE_10) Command phase after boot code
      boot_link_pkg::ST_SEND_BOOT: begin
        if (send_done) begin
          state_next = boot_link_pkg::ST_CMD;
        end
      end
      boot_link_pkg::ST_CMD: state_next = boot_link_pkg::ST_CMD;
      boot_link_pkg::ST_SW_RESET: state_next = boot_link_pkg::ST_SW_RESET;
      default: state_next = boot_link_pkg::ST_INIT;
    endcase
  end
  // Phase register; only reset leaves the final phases
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= boot_link_pkg::ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end
  // Bring-up counter also covers synchroniser settling
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_cnt_reg <= 4'h0;
    end else if (state_reg == boot_link_pkg::ST_INIT) begin
      init_cnt_reg <= init_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Boot-mode capture and link choice
  // ----------------------------------------------------------------
  // (RULE_20) One-time capture, held until reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_latched_reg <= 1'b0;
      dbm_latched_reg <= 8'h00;
    end else if (state_reg == boot_link_pkg::ST_SAMPLE) begin
      mode_latched_reg <= mode_sync_reg;
      dbm_latched_reg <= dbm_sync_reg;
    end
  end
  // Link stays fixed once chosen
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_reg <= boot_link_pkg::LINK_NONE;
    end else if ((state_reg == boot_link_pkg::ST_SAMPLE) &&
                 (state_next == boot_link_pkg::ST_WAIT_GENERIC)) begin
      link_reg <= boot_link_pkg::LINK_MBOX;
    end else if (hit_uart) begin
      link_reg <= boot_link_pkg::LINK_UART;
    end else if (hit_usb) begin
      link_reg <= boot_link_pkg::LINK_USB;
    end
  end

  // (RULE_04) Run broken by other value or other link
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zero_cnt_reg <= 2'h0;
      zero_src_reg <= boot_link_pkg::LINK_NONE;
    end else if ((state_reg != boot_link_pkg::ST_WAIT_ZERO) || both_rx) begin
      zero_cnt_reg <= 2'h0;
      zero_src_reg <= boot_link_pkg::LINK_NONE;
    end else if (uart_zero) begin
      zero_src_reg <= boot_link_pkg::LINK_UART;
      zero_cnt_reg <= (zero_src_reg == boot_link_pkg::LINK_UART) ? zero_cnt_reg + 2'h1 : 2'h1;
    end else if (usb_zero) begin
      zero_src_reg <= boot_link_pkg::LINK_USB;
      zero_cnt_reg <= (zero_src_reg == boot_link_pkg::LINK_USB) ? zero_cnt_reg + 2'h1 : 2'h1;
    end else if (uart_rx_valid || usb_rx) begin
      zero_cnt_reg <= 2'h0;
      zero_src_reg <= boot_link_pkg::LINK_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Transmit pin and phase outputs
  // ----------------------------------------------------------------
  // (RULE_14) Pull-up first on newer firmware, drive after three zeros
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_txd_oe <= 1'b0;
      o_txd_pullup_en <= 1'b0;
    end else if (state_reg == boot_link_pkg::ST_SAMPLE) begin
      o_txd_oe <= !fw_ge3_reg;
      o_txd_pullup_en <= fw_ge3_reg;
    end else if (hit_uart) begin
      o_txd_oe <= 1'b1;
    end
  end
  // Idle-high line from the transceiver
  assign o_txd = uart_txd;

  // USB offered to the host unless the mailbox or the soft reset took over
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_usb_enumerable <= 1'b0;
    end else if (state_reg == boot_link_pkg::ST_SAMPLE) begin
      // (RULE_15) Enumerable after bring-up
      o_usb_enumerable <= (state_next == boot_link_pkg::ST_WAIT_ZERO);
    end
  end
  // Command bytes of the chosen link go to the packet layer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cmd_rx_valid <= 1'b0;
      o_cmd_rx_data <= 8'h00;
    end else begin
      o_cmd_rx_valid <= (state_reg == boot_link_pkg::ST_CMD) && sel_rx_valid;
      o_cmd_rx_data <= sel_rx_data;
    end
  end
  assign o_cmd_phase = (state_reg == boot_link_pkg::ST_CMD);
  assign o_soft_reset = (state_reg == boot_link_pkg::ST_SW_RESET);
  assign o_link = link_reg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Firmware level is read at capture, so late writes have no effect
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fw_ge3_reg <= boot_link_pkg::CTRL_FW_GE3_RESET;
      bit_cycles_reg <= BIT_CYCLES;
    end else if (i_wr_en) begin
      if (i_addr == boot_link_pkg::REG_CTRL) begin
        fw_ge3_reg <= i_wr_data[boot_link_pkg::CTRL_FW_GE3_BIT];
      end
      // (RULE_19) Rate changes only by command
      if (i_addr == boot_link_pkg::REG_BAUD) begin
        bit_cycles_reg <= i_wr_data[15:0];
      end
    end
  end
  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 32'h0000_0000;
    end else begin
      o_rd_data <= 32'h0000_0000;
      if (i_rd_en) begin
        case (i_addr)
          boot_link_pkg::REG_CTRL: o_rd_data[boot_link_pkg::CTRL_FW_GE3_BIT] <= fw_ge3_reg;
          boot_link_pkg::REG_STATUS: begin
            o_rd_data[boot_link_pkg::STATUS_STATE_LSB +: 8] <= state_reg;
            o_rd_data[boot_link_pkg::STATUS_LINK_LSB +: 2] <= link_reg;
            o_rd_data[boot_link_pkg::STATUS_ZCNT_LSB +: 2] <= zero_cnt_reg;
            o_rd_data[boot_link_pkg::STATUS_MODE_BIT] <= mode_latched_reg;
            o_rd_data[boot_link_pkg::STATUS_DBM_LSB +: 8] <= dbm_latched_reg;
          end
          boot_link_pkg::REG_BAUD: o_rd_data[15:0] <= bit_cycles_reg;
          default: o_rd_data <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/boot_link_pkg.sv
/*
  Shared constants for the boot-time link establishment block: codes,
  register offsets, reset values, cycle counts and the phase encoding.
  Assumes a single 100 MHz clock domain for all users of the package.
*/
`default_nettype none

package boot_link_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned UART_BPS_INIT = 9600;
  // Whole clock cycles per bit at the initial line rate
  localparam int unsigned BIT_CYCLES_INIT = CLK_HZ / UART_BPS_INIT;
  // Hardware bring-up time before the link setting phase
  localparam logic [3:0] INIT_CYCLES = 4'hf;

  // ----------------------------------------------------------------
  // Link codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] ACK_BYTE = 8'h00;
  localparam logic [7:0] GENERIC_CODE = 8'h55;
  localparam logic [7:0] BOOT_CODE = 8'hc6;
  localparam logic [7:0] MAGIC_CODE = 8'ha5;
  localparam logic [1:0] ZERO_RUN = 2'h3;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BAUD = 8'h08;
  localparam int unsigned CTRL_FW_GE3_BIT = 0;
  localparam logic CTRL_FW_GE3_RESET = 1'b1;
  localparam int unsigned STATUS_STATE_LSB = 0;
  localparam int unsigned STATUS_LINK_LSB = 8;
  localparam int unsigned STATUS_ZCNT_LSB = 10;
  localparam int unsigned STATUS_MODE_BIT = 12;
  localparam int unsigned STATUS_DBM_LSB = 16;

  // ----------------------------------------------------------------
  // Phases and links
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_SAMPLE = 8'h02,
    ST_WAIT_ZERO = 8'h04,
    ST_SEND_ACK = 8'h08,
    ST_WAIT_GENERIC = 8'h10,
    ST_SEND_BOOT = 8'h20,
    ST_CMD = 8'h40,
    ST_SW_RESET = 8'h80
  } boot_state_e;

  typedef enum logic [1:0] {
    LINK_NONE = 2'h0,
    LINK_UART = 2'h1,
    LINK_USB = 2'h2,
    LINK_MBOX = 2'h3
  } link_e;

endpackage

`default_nettype wire

// file: verilog/uart_link.sv
/*
  Byte-level two-wire serial transceiver: 8 data bits, LSB first, no
  parity, one stop bit. Bit period in clock cycles comes from a port.
  Assumes the receive pin is asynchronous to i_clk.
*/
`default_nettype none

module uart_link (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [15:0] i_bit_cycles,
  input wire logic i_rxd,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_tx_start,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_busy,
  output logic o_txd
);

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic rx_active_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;

  // Two-stage synchroniser, idle line is high
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= i_rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // Sample mid-bit; a start glitch shorter than half a bit is dropped
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_active_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
    end else begin
      o_rx_valid <= 1'b0;
      if (!rx_active_reg) begin
        if (!rxd_sync_reg) begin
          rx_active_reg <= 1'b1;
          rx_cnt_reg <= i_bit_cycles >> 1;
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= i_bit_cycles - 16'h0001;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          rx_active_reg <= !rxd_sync_reg;
        end else if (rx_bit_reg == 4'h9) begin
          rx_active_reg <= 1'b0;
          o_rx_valid <= rxd_sync_reg;     // Framing error drops the byte
          o_rx_data <= rx_shift_reg;
        end else begin
          rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [9:0] tx_shift_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0] tx_left_reg;

  // Start bit, data LSB first, stop bit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_shift_reg <= 10'h3ff;
      tx_cnt_reg <= 16'h0000;
      tx_left_reg <= 4'h0;
    end else if (tx_left_reg == 4'h0) begin
      if (i_tx_start) begin
        tx_shift_reg <= {1'b1, i_tx_data, 1'b0};
        tx_cnt_reg <= i_bit_cycles - 16'h0001;
        tx_left_reg <= 4'ha;
      end
    end else if (tx_cnt_reg != 16'h0000) begin
      tx_cnt_reg <= tx_cnt_reg - 16'h0001;
    end else begin
      tx_cnt_reg <= i_bit_cycles - 16'h0001;
      tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
      tx_left_reg <= tx_left_reg - 4'h1;
    end
  end

  assign o_tx_busy = (tx_left_reg != 4'h0);
  assign o_txd = tx_shift_reg[0];

endmodule

`default_nettype wire

// file: tb/boot_link_asserts.sv
/* Port checks for boot_link.
   Bound to the design; one clock, async low reset. */
`default_nettype none
module boot_link_asserts (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_usb_rx_valid,
  input wire logic i_mbox_rx_valid,
  input wire logic [7:0] i_mbox_rx_data,
  input wire logic o_usb_tx_valid,
  input wire logic [7:0] o_usb_tx_data,
  input wire logic o_mbox_tx_valid,
  input wire logic [7:0] o_mbox_tx_data,
  input wire logic [1:0] o_link,
  input wire logic o_cmd_phase,
  input wire logic o_soft_reset,
  input wire logic o_usb_enumerable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------
  // Relations
  // ---------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Generic code seen on the chosen mailbox
  sequence s_generic;
    i_mbox_rx_valid && i_mbox_rx_data == 8'h55 && o_link == 2'h3;
  endsequence
  AST_INIT_QUIET: assert property ($rose(i_arst_n) |->
    (o_link == 2'h0 && !o_usb_enumerable)[*8]) else $error("link before init");
  AST_SOFT_HOLD: assert property (o_soft_reset |=> o_soft_reset && !o_usb_enumerable)
    else $error("soft reset dropped");
  AST_CMD_HOLD: assert property (o_cmd_phase |=> o_cmd_phase)
    else $error("command phase left");
  AST_LINK_KEEP: assert property (o_link != 2'h0 |=> $stable(o_link))
    else $error("link changed");
  AST_USB_CODES: assert property (o_usb_tx_valid |-> o_link == 2'h2 &&
    (o_usb_tx_data == 8'h00 || o_usb_tx_data == 8'hc6)) else $error("bad usb byte");
  AST_MBOX_NO_ACK: assert property (o_mbox_tx_valid |-> o_mbox_tx_data == 8'hc6)
    else $error("mailbox sent other than boot code");
  AST_MBOX_ANSWER: assert property (s_generic ##0 (!o_cmd_phase && !o_mbox_tx_valid)
    |=> o_mbox_tx_valid) else $error("no boot code");
  AST_TX_CAUSE: assert property ($rose(o_usb_tx_valid) |-> $past(i_usb_rx_valid))
    else $error("usb byte sent unprompted");
endmodule
`default_nettype wire

// file: tb/boot_host.sv
/* Serial host model: 8N1 frames, BIT cycles a bit.
   Expects the device line level already resolved. */
`default_nettype none
module boot_host #(parameter int BIT = 16) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_rxd = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------
  // Frames
  // ---------------------------------------
  // start, LSB first, stop
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd <= f[i];
      repeat (BIT) @(posedge i_clk);
    end
  endtask
  task automatic recv(output logic [7:0] d);
    @(negedge i_line);
    repeat (BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      d[i] = i_line;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/boot_link_tb_top.sv
/* Bench for boot_link: serial host, byte pipes, registers.
   Assumes a 16-cycle bit period. */
`default_nettype none
module boot_link_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_arst_n = 1'b0, pin = 1'b0, blank = 1'b1, uv = 1'b0, mv = 1'b0;
  logic rd = 1'b0, wr = 1'b0, txd, oe, pu, en, utv, mtv, srst, cmd, rxd;
  logic cfg = 1'b1, rdy = 1'b1, crv;
  logic [7:0] magic = 8'h00, bd = 8'h00, addr = 8'h00, utd, mtd, crd;
  logic [31:0] wd = 32'h0, rdd;
  logic [1:0] link;
  int failures = 0, n_checks = 0;
  // Pull-up holds the line when the device lets go
  wire logic line = oe ? txd : pu;
  boot_link #(.BIT_CYCLES(16'h0010)) u_boot_link (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_boot_mode_pin(pin), .i_debug_boot_mode(magic), .i_user_area_blank(blank),
    .i_rxd(rxd), .o_txd(txd), .o_txd_oe(oe), .o_txd_pullup_en(pu), .o_usb_enumerable(en),
    .i_usb_configured(cfg), .i_usb_rx_valid(uv), .i_usb_rx_data(bd), .o_usb_tx_valid(utv),
    .o_usb_tx_data(utd), .i_usb_tx_ready(rdy), .i_mbox_rx_valid(mv), .i_mbox_rx_data(bd),
    .o_mbox_tx_valid(mtv), .o_mbox_tx_data(mtd), .i_mbox_tx_ready(rdy),
    .o_soft_reset(srst), .o_cmd_phase(cmd), .o_link(link), .o_cmd_rx_valid(crv),
    .o_cmd_rx_data(crd), .i_addr(addr), .i_wr_data(wd), .i_wr_en(wr), .i_rd_en(rd),
    .o_rd_data(rdd));
  boot_host #(.BIT(16)) u_boot_host (.i_clk(i_clk), .i_line(line), .o_rxd(rxd));
  // ---------------------------------------
  // Tasks
  // ---------------------------------------
  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    n_checks++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rst(input logic p, input logic [7:0] m, input logic b);
    @(posedge i_clk);
    {i_arst_n, pin, magic, blank} <= {1'b0, p, m, b};
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (24) @(posedge i_clk);
  endtask
  // One register access; a read checks the low byte
  task automatic reg_acc(input logic w, input logic [7:0] a, d, e);
    @(posedge i_clk);
    {wr, rd, addr, wd} <= {w, !w, a, 24'h0, d};
    @(posedge i_clk);
    {wr, rd} <= 2'b00;
    #1 if (!w) ck(rdd[7:0], e);
  endtask
  // one byte on USB (m low) or mailbox (m high), never overlapping
  task automatic pb(input logic m, input logic [7:0] d);
    @(posedge i_clk);
    {uv, mv, bd} <= {!m, m, d};
    @(posedge i_clk);
    {uv, mv} <= 2'b00;
  endtask
  // Waits a bounded time for a pipe byte from the device
  task automatic tx(input logic [7:0] e);
    repeat (20) begin
      #1;
      if (utv | mtv) break;
      @(posedge i_clk);
    end
    ck({7'h0, utv | mtv}, 8'h01);
    ck(utd | mtd, e);
  endtask
  initial forever #5 i_clk = ~i_clk;
  // Watchdog well beyond the expected 14 us
  initial begin
    #100us;
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d;
    logic [7:0] zs [5] = '{8'h00, 8'h00, 8'h55, 8'h00, 8'h00};
    rst(1'b0, 8'h00, 1'b1);
    reg_acc(1'b0, 8'h00, 8'h00, 8'h01);
    reg_acc(1'b1, 8'h0c, 8'hff, 8'h00);
    reg_acc(1'b0, 8'h0c, 8'h00, 8'h00);
    ck({6'h0, pu, oe}, 8'h02);
    foreach (zs[i]) pb(1'b0, zs[i]);
    u_boot_host.send(8'h00);
    repeat (2) pb(1'b0, 8'h00);
    cfg <= 1'b0;
    pb(1'b0, 8'h00);
    cfg <= 1'b1;
    ck({6'h0, link}, 8'h00);
    pb(1'b0, 8'h00);
    tx(8'h00);
    ck({6'h0, oe, cmd}, 8'h00);
    pb(1'b0, 8'h33);
    #1 ck({7'h0, utv}, 8'h00);
    pb(1'b0, 8'h55);
    tx(8'hc6);
    @(posedge i_clk);
    #1 ck({5'h0, cmd, link}, 8'h06);
    pb(1'b0, 8'h5a);
    #1 ck(crd & {8{crv}}, 8'h5a);
    rst(1'b0, 8'h00, 1'b1);
    repeat (2) u_boot_host.send(8'h00);
    fork
      u_boot_host.send(8'h00);
      u_boot_host.recv(d);
    join
    ck(d, 8'h00);
    ck({7'h0, oe}, 8'h01);
    repeat (30) @(posedge i_clk);
    fork
      u_boot_host.send(8'h55);
      u_boot_host.recv(d);
    join
    ck(d, 8'hc6);
    ck({7'h0, cmd}, 8'h00);
    repeat (30) @(posedge i_clk);
    ck({5'h0, cmd, link}, 8'h05);
    rst(1'b1, 8'ha5, 1'b0);
    {pin, magic} <= 9'h000;
    repeat (4) @(posedge i_clk);
    ck({5'h0, link, en}, 8'h06);
    pb(1'b1, 8'h00);
    #1 ck({7'h0, mtv}, 8'h00);
    rdy <= 1'b0;
    pb(1'b1, 8'h55);
    tx(8'hc6);
    repeat (3) @(posedge i_clk);
    tx(8'hc6);
    rdy <= 1'b1;
    @(posedge i_clk);
    #1 ck({5'h0, cmd, link}, 8'h07);
    rst(1'b1, 8'h00, 1'b0);
    ck({6'h0, srst, en}, 8'h02);
    rst(1'b1, 8'h00, 1'b1);
    ck({6'h0, srst, en}, 8'h01);
    tally_and_finish();
  end
endmodule
bind boot_link boot_link_asserts u_boot_link_asserts (.i_clk, .i_arst_n, .i_usb_rx_valid,
  .i_mbox_rx_valid, .i_mbox_rx_data, .o_usb_tx_valid, .o_usb_tx_data, .o_mbox_tx_valid,
  .o_mbox_tx_data, .o_link, .o_cmd_phase, .o_soft_reset, .o_usb_enumerable);
`default_nettype wire
